// ===== heat_alarm_map.svh
// Register offsets, field positions, levels and timing figures of the heat alarm evaluator.
`ifndef HEAT_ALARM_MAP_SVH
`define HEAT_ALARM_MAP_SVH
// Register byte offsets.
`define CTRL_OFS     8'h00
`define CLASS_OFS    8'h04
`define ZMAP_OFS     8'h08
`define GROUP_OFS    8'h0c
`define UDEP_OFS     8'h10
`define STATUS_OFS   8'h14
`define CLEAR_OFS    8'h18
`define IRQEN_OFS    8'h1c
`define ALARM_OFS    8'h20
`define MM_BASE      8'h40
`define MM_MASK      8'he3
// Control bit positions.
`define CTRL_PRE_EN  0
`define CTRL_COINC   1
`define CTRL_ALT     2
// Status bit positions.
`define ST_FIRE      0
`define ST_PRE       1
`define ST_HEAVY     2
`define ST_FAULT     3
`define ST_COINC     4
// Alarm levels in degrees Celsius.
`define A1_FIRE      8'h38
`define A1_PRE       8'h2e
`define A1_FAST_FIRE 8'h2e
`define A1_FAST_PRE  8'h24
`define A2_FIRE      8'h3c
`define A2_PRE       8'h32
`define B_FIRE       8'h4a
`define B_PRE        8'h40
`define HEAVY_LVL    8'h5a
// Confirmation and coincidence figures.
`define CONFIRM      2'h3
`define PAIR         4'h2
`define ONE          4'h1
`define GRP_MAX      4'ha
`define MIN_INIT     8'hff
`define MAX_INIT     8'h00
// Timing figures.
`define CLK_KHZ      32'd50000
`define BUZ_PERIOD_MS 32'd5000
`define BUZ_ON_MS    32'd800
`define POLL_MS      32'd60000
`endif

// ===== heat_alarm_pkg.sv
// Types shared by the heat alarm evaluator.
package heat_alarm_pkg;
  localparam int NDET  = 8;   // Number of heat detectors handled.
  localparam int NZONE = 8;   // Number of zones.
  localparam int NGRP  = 16;  // Group code space; codes 1 to 10 are used.
  typedef enum logic [1:0] {CLS_A1 = 2'b00, CLS_A2S = 2'b01, CLS_BS = 2'b10} heat_class_t;
  typedef enum logic [1:0] {POLL_IDLE = 2'b00, POLL_RUN = 2'b01} poll_state_t;
  typedef struct packed {
    logic [2:0] det;   // Detector address.
    logic [7:0] temp;  // Temperature in degrees Celsius.
    logic       fault; // Self-check fault reported in the reply.
    logic       fast;  // Rise above 4 degrees per minute.
  } sample_t;
  typedef struct packed {
    logic [7:0] pre;
    logic [7:0] fire;
    logic [7:0] heavy;
  } levels_t;
endpackage

// ===== heat_alarm_coincidence_eval.sv
// Heat detector alarm evaluation with daily min/max and zone/unit coincidence gating.
//
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "heat_alarm_map.svh"
// Operation
// - Regular or alternative class chosen by time channel.
// - Fire needs three consecutive samples above level.
// - Pre-warning same confirmation, only when enabled.
// - Heavy heat same confirmation, higher level.
// - A1 slow rise: 56, 46, 90.
// - A1 fast rise: 46, 36, 90.
// - A2 S: 60, 50, 90.
// - B S: 74, 64, 90.
// - Poll every minute; reported fault raises system fault.
// - Track running min and max per detector.
// - Midnight copies min/max to readable store.
// - Time channel switches coincidence gating as whole.
// - Dependent zone belongs to group one to ten.
// - Zone fire needs two zones of group.
// - Unit fire needs two units in zone.
// - Single dependent: buzzer cadence and coincidence indication.
// - Single dependent drives only dependent outputs.
module heat_alarm_coincidence_eval #(
  parameter int unsigned BUZ_PERIOD_CYC = `BUZ_PERIOD_MS * `CLK_KHZ,
  parameter int unsigned BUZ_ON_CYC     = `BUZ_ON_MS * `CLK_KHZ,
  parameter int unsigned POLL_CYC       = `POLL_MS * `CLK_KHZ
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [7:0]              adr_i,
  input  wire logic [31:0]             dat_i,
  input  wire logic [3:0]              sel_i,
  output logic      [31:0]             dat_o,
  output logic                         ack_o,
  input  wire logic                    smp_valid_i,
  input  wire heat_alarm_pkg::sample_t sample_i,
  input  wire logic                    alt_tc_i,
  input  wire logic                    coinc_tc_i,
  input  wire logic                    midnight_i,
  output logic                         poll_req_o,
  output logic      [2:0]              poll_addr_o,
  output logic                         fire_alarm_o,
  output logic                         prewarn_o,
  output logic                         heavy_o,
  output logic                         fault_o,
  output logic                         zone_dep_o,
  output logic                         unit_dep_o,
  output logic                         coinc_ind_o,
  output logic                         buzzer_o,
  output logic                         irq_o
);
  localparam int ND = heat_alarm_pkg::NDET;
  localparam int NZ = heat_alarm_pkg::NZONE;

  // ************************************************************
  // Register bus and configuration
  // ************************************************************
  logic [2:0]  ctrl_q;          // Pre-warning enable, coincidence, alternative class.
  logic [31:0] cls_q;           // Regular classes low half, alternative high half.
  logic [23:0] zmap_q;          // Zone of each detector, three bits each.
  logic [31:0] grp_q;           // Group of each zone, four bits each.
  logic [7:0]  udep_q;          // Unit-dependent detector mask.
  logic [4:0]  status_q;        // Sticky event flags.
  logic [4:0]  status_d;        // Next value of the sticky flags.
  logic [4:0]  irqen_q;         // Interrupt enables.
  logic [4:0]  clr;             // Clear strobe from software.
  logic [4:0]  ev;              // Events of this cycle.
  logic [31:0] wm;              // Byte-lane write mask.
  logic        wr;              // Write accepted this cycle.
  logic        ack_q;

  assign wm = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wr = cyc_i && stb_i && we_i && ack_q; // Lands on the edge where the master sees ack.
  assign clr = (wr && adr_i == `CLEAR_OFS) ? dat_i[4:0] & wm[4:0] : 5'h00;
  assign ack_o = ack_q;

  // Writable configuration; partial lanes keep the old bits.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q  <= 3'h0;
      cls_q   <= 32'h0;
      zmap_q  <= 24'h0;
      grp_q   <= 32'h0;
      udep_q  <= 8'h0;
      irqen_q <= 5'h0;
    end
    else if (wr)
    begin
      case (adr_i)
        `CTRL_OFS:  ctrl_q  <= (ctrl_q & ~wm[2:0]) | (dat_i[2:0] & wm[2:0]);
        `CLASS_OFS: cls_q   <= (cls_q & ~wm) | (dat_i & wm);
        `ZMAP_OFS:  zmap_q  <= (zmap_q & ~wm[23:0]) | (dat_i[23:0] & wm[23:0]);
        `GROUP_OFS: grp_q   <= (grp_q & ~wm) | (dat_i & wm);
        `UDEP_OFS:  udep_q  <= (udep_q & ~wm[7:0]) | (dat_i[7:0] & wm[7:0]);
        `IRQEN_OFS: irqen_q <= (irqen_q & ~wm[4:0]) | (dat_i[4:0] & wm[4:0]);
        default:    ctrl_q  <= ctrl_q;
      endcase
    end
  end

  // ************************************************************
  // Level selection
  // ************************************************************
  logic                        alt_on;    // Alternative class in use.
  logic                        coinc_on;  // Coincidence gating in force.
  logic [15:0]                 cls_alt;
  heat_alarm_pkg::heat_class_t cur_cls;   // Class of the sample now arriving.
  heat_alarm_pkg::levels_t     lvl;       // Its three levels.

  // Either the internal bit or the external channel may select.
  assign alt_on   = ctrl_q[`CTRL_ALT] | alt_tc_i;
  assign coinc_on = ctrl_q[`CTRL_COINC] | coinc_tc_i;
  assign cls_alt  = cls_q[31:16];
  assign cur_cls  = heat_alarm_pkg::heat_class_t'(alt_on ? cls_alt[{sample_i.det, 1'b0} +: 2]
                                                         : cls_q[{sample_i.det, 1'b0} +: 2]);

  // Levels per class; an unused class code falls back to the A1 table.
  function automatic heat_alarm_pkg::levels_t levels_of(input heat_alarm_pkg::heat_class_t c,
                                                        input logic fast);
    heat_alarm_pkg::levels_t l;
    l.heavy = `HEAVY_LVL;
    case (c)
      heat_alarm_pkg::CLS_A2S:
      begin
        l.fire = `A2_FIRE;
        l.pre  = `A2_PRE;
      end
      heat_alarm_pkg::CLS_BS:
      begin
        l.fire = `B_FIRE;
        l.pre  = `B_PRE;
      end
      default:
      begin
        l.fire = fast ? `A1_FAST_FIRE : `A1_FIRE;
        l.pre  = fast ? `A1_FAST_PRE : `A1_PRE;
      end
    endcase
    return l;
  endfunction

  assign lvl = levels_of(cur_cls, sample_i.fast);

  // Count up to the confirmation figure while above, back to zero otherwise.
  function automatic logic [1:0] bump(input logic [1:0] c, input logic above);
    return above ? ((c == `CONFIRM) ? c : c + 2'h1) : 2'h0;
  endfunction

  // ************************************************************
  // Per-detector confirmation, fault and min/max
  // ************************************************************
  logic [1:0] fire_cnt  [ND];
  logic [1:0] pre_cnt   [ND];
  logic [1:0] heavy_cnt [ND];
  logic [7:0] run_min   [ND];
  logic [7:0] run_max   [ND];
  logic [7:0] st_min    [ND];
  logic [7:0] st_max    [ND];
  logic [ND-1:0] fire_st;  // Detector in fire state.
  logic [ND-1:0] pre_st;   // Detector in pre-warning state.
  logic [ND-1:0] heavy_st; // Detector in heavy heat state.
  logic [ND-1:0] fault_q;  // Last reply carried a fault.

  for (genvar d = 0; d < ND; d++)
  begin : g_det
    logic       hit;
    logic [7:0] nmin;
    logic [7:0] nmax;
    assign hit  = smp_valid_i && sample_i.det == 3'(d);
    assign nmin = (hit && sample_i.temp < run_min[d]) ? sample_i.temp : run_min[d];
    assign nmax = (hit && sample_i.temp > run_max[d]) ? sample_i.temp : run_max[d];
    assign fire_st[d]  = fire_cnt[d] == `CONFIRM;
    assign pre_st[d]   = pre_cnt[d] == `CONFIRM;
    assign heavy_st[d] = heavy_cnt[d] == `CONFIRM;

    // Only samples of this detector move its counters, save pre_cnt, which a cleared enable zeroes.
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        fire_cnt[d]  <= 2'h0;
        pre_cnt[d]   <= 2'h0;
        heavy_cnt[d] <= 2'h0;
      end
      else
      begin
        if (hit)
        begin
          fire_cnt[d]  <= bump(fire_cnt[d], sample_i.temp > lvl.fire);
          heavy_cnt[d] <= bump(heavy_cnt[d], sample_i.temp > lvl.heavy);
        end
        if (!ctrl_q[`CTRL_PRE_EN])
          pre_cnt[d] <= 2'h0;
        else if (hit)
          pre_cnt[d] <= bump(pre_cnt[d], sample_i.temp > lvl.pre);
      end
    end

    // Fault stays until a clean reply from the same detector.
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        fault_q[d] <= 1'b0;
      else if (hit)
        fault_q[d] <= sample_i.fault;
    end

    // A sample in the midnight cycle still counts for the day that ends.
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        run_min[d] <= `MIN_INIT;
        run_max[d] <= `MAX_INIT;
        st_min[d]  <= `MIN_INIT;
        st_max[d]  <= `MAX_INIT;
      end
      else if (midnight_i)
      begin
        st_min[d]  <= nmin;
        st_max[d]  <= nmax;
        run_min[d] <= `MIN_INIT;
        run_max[d] <= `MAX_INIT;
      end
      else
      begin
        run_min[d] <= nmin;
        run_max[d] <= nmax;
      end
    end
  end

  // ************************************************************
  // Coincidence gating
  // ************************************************************
  logic [3:0]    ucnt [NZ];                  // Unit-dependent detectors in fire per zone.
  logic [3:0]    gcnt [heat_alarm_pkg::NGRP]; // Zones in fire per group.
  logic [NZ-1:0] zfire;                      // Zone in fire state.
  logic [NZ-1:0] zdep;                       // Zone is zone-dependent now.
  logic          gen_fire;                   // General fire alarm.
  logic          zsingle;                    // Lone dependent zone in fire.
  logic          usingle;                    // Lone dependent unit in fire.

  // Unit pairs are resolved first, then zone pairs inside their groups.
  always_comb
  begin
    gen_fire = 1'b0;
    zsingle  = 1'b0;
    usingle  = 1'b0;
    zfire    = '0;
    zdep     = '0;
    for (int z = 0; z < NZ; z++)
      ucnt[z] = 4'h0;
    for (int g = 0; g < heat_alarm_pkg::NGRP; g++)
      gcnt[g] = 4'h0;
    for (int d = 0; d < ND; d++)
      if (fire_st[d] && udep_q[d] && coinc_on)
        ucnt[zmap_q[3*d +: 3]] = ucnt[zmap_q[3*d +: 3]] + `ONE;
    for (int d = 0; d < ND; d++)
    begin
      if (fire_st[d] && (!(udep_q[d] && coinc_on) || ucnt[zmap_q[3*d +: 3]] >= `PAIR))
        zfire[zmap_q[3*d +: 3]] = 1'b1;
      if (fire_st[d] && udep_q[d] && coinc_on && ucnt[zmap_q[3*d +: 3]] == `ONE)
        usingle = 1'b1;
    end
    for (int z = 0; z < NZ; z++)
    begin
      // Codes outside one to ten leave the zone independent.
      zdep[z] = coinc_on && grp_q[4*z +: 4] != 4'h0 && grp_q[4*z +: 4] <= `GRP_MAX;
      if (zfire[z] && zdep[z])
        gcnt[grp_q[4*z +: 4]] = gcnt[grp_q[4*z +: 4]] + `ONE;
    end
    for (int z = 0; z < NZ; z++)
    begin
      if (zfire[z] && !zdep[z])
        gen_fire = 1'b1;
      else if (zfire[z] && gcnt[grp_q[4*z +: 4]] >= `PAIR)
        gen_fire = 1'b1;
      else if (zfire[z])
        zsingle = 1'b1;
    end
  end

  // ************************************************************
  // Outputs, buzzer cadence and interrupt
  // ************************************************************
  logic        buz_act;   // Buzzer pattern wanted.
  logic [31:0] buz_cnt_q; // Position in the five second period.

  assign buz_act = zsingle | usingle | (|pre_st);

  // The cadence restarts whenever it stops, so each episode opens with a tone.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !buz_act)
      buz_cnt_q <= 32'h0;
    else if (buz_cnt_q >= BUZ_PERIOD_CYC - 32'h1)
      buz_cnt_q <= 32'h0;
    else
      buz_cnt_q <= buz_cnt_q + 32'h1;
  end

  // The general fire alarm stays off while a dependent point is alone in fire.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fire_alarm_o <= 1'b0;
      prewarn_o    <= 1'b0;
      heavy_o      <= 1'b0;
      fault_o      <= 1'b0;
      zone_dep_o   <= 1'b0;
      unit_dep_o   <= 1'b0;
      coinc_ind_o  <= 1'b0;
      buzzer_o     <= 1'b0;
    end
    else
    begin
      fire_alarm_o <= gen_fire;
      prewarn_o    <= |pre_st;
      heavy_o      <= |heavy_st;
      fault_o      <= |fault_q;
      zone_dep_o   <= zsingle;
      unit_dep_o   <= usingle;
      coinc_ind_o  <= zsingle | usingle;
      buzzer_o     <= buz_act && buz_cnt_q < BUZ_ON_CYC;
    end
  end

  // Rising edges of the alarm states are the interrupt events.
  assign ev = {(zsingle | usingle) & ~coinc_ind_o, (|fault_q) & ~fault_o,
               (|heavy_st) & ~heavy_o, (|pre_st) & ~prewarn_o, gen_fire & ~fire_alarm_o};
  assign status_d = (status_q & ~clr) | ev; // A new event beats a clear.

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status_q <= 5'h00;
      irq_o    <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      irq_o    <= |(status_d & irqen_q);
    end
  end

  // Single-cycle answer; unmapped reads return zero.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_o <= 32'h0;
    end
    else
    begin
      ack_q <= cyc_i && stb_i && !ack_q;
      dat_o <= 32'h0;
      if (cyc_i && stb_i && !we_i && !ack_q)
      begin
        if ((adr_i & `MM_MASK) == `MM_BASE)
          dat_o <= {16'h0, st_max[adr_i[4:2]], st_min[adr_i[4:2]]};
        else
          case (adr_i)
            `CTRL_OFS:   dat_o <= {29'h0, ctrl_q};
            `CLASS_OFS:  dat_o <= cls_q;
            `ZMAP_OFS:   dat_o <= {8'h0, zmap_q};
            `GROUP_OFS:  dat_o <= grp_q;
            `UDEP_OFS:   dat_o <= {24'h0, udep_q};
            `STATUS_OFS: dat_o <= {27'h0, status_q};
            `IRQEN_OFS:  dat_o <= {27'h0, irqen_q};
            `ALARM_OFS:  dat_o <= {fault_q, heavy_st, pre_st, fire_st};
            default:     dat_o <= 32'h0;
          endcase
      end
    end
  end

  // ************************************************************
  // Minute poll of all detectors
  // ************************************************************
  heat_alarm_pkg::poll_state_t poll_st_q;
  logic [31:0]                 poll_cnt_q;
  logic                        poll_tick;

  assign poll_tick = poll_cnt_q == POLL_CYC - 32'h1;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || poll_tick)
      poll_cnt_q <= 32'h0;
    else
      poll_cnt_q <= poll_cnt_q + 32'h1;
  end

  // One query per detector in consecutive cycles after each tick.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      poll_st_q   <= heat_alarm_pkg::POLL_IDLE;
      poll_req_o  <= 1'b0;
      poll_addr_o <= 3'h0;
    end
    else
    begin
      case (poll_st_q)
        heat_alarm_pkg::POLL_IDLE:
          if (poll_tick)
          begin
            poll_st_q   <= heat_alarm_pkg::POLL_RUN;
            poll_req_o  <= 1'b1;
            poll_addr_o <= 3'h0;
          end
        heat_alarm_pkg::POLL_RUN:
          if (poll_addr_o == 3'(ND - 1))
          begin
            poll_st_q  <= heat_alarm_pkg::POLL_IDLE;
            poll_req_o <= 1'b0;
          end
          else
            poll_addr_o <= poll_addr_o + 3'h1;
        default:
        begin
          poll_st_q  <= heat_alarm_pkg::POLL_IDLE;
          poll_req_o <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // One sample for detector 0 on the loop side.
  sequence s_det0_hit;
    smp_valid_i && sample_i.det == 3'h0;
  endsequence
  // The third exceeding sample in a row for detector 0.
  sequence s_det0_third;
    s_det0_hit ##0 (sample_i.temp > lvl.fire && fire_cnt[0] == 2'h2);
  endsequence

  AST_FIRE_CONFIRM: assert property ($rose(fire_st[0]) |->
                    $past(smp_valid_i && sample_i.det == 3'h0 && sample_i.temp > lvl.fire))
    else $error("Fire state rose without an exceeding sample.");
  AST_FIRE_THIRD: assert property (s_det0_third |=> fire_st[0])
    else $error("Third exceeding sample gave no fire state.");
  AST_CLEAR_BELOW: assert property ((s_det0_hit ##0 sample_i.temp <= lvl.fire) |=>
                   fire_cnt[0] == 2'h0)
    else $error("Confirmation count not cleared.");
  AST_PRE_GATE: assert property ((!ctrl_q[`CTRL_PRE_EN] ##1 !ctrl_q[`CTRL_PRE_EN]) |=> !prewarn_o)
    else $error("Pre-warning while disabled.");
  AST_A1_LEVELS: assert property ((cur_cls == heat_alarm_pkg::CLS_A1 && !sample_i.fast) |->
                 (lvl.fire == `A1_FIRE && lvl.pre == `A1_PRE && lvl.heavy == `HEAVY_LVL))
    else $error("Wrong A1 levels.");
  AST_BS_LEVELS: assert property ((cur_cls == heat_alarm_pkg::CLS_BS) |->
                 (lvl.fire == `B_FIRE && lvl.pre == `B_PRE))
    else $error("Wrong B S levels.");
  AST_FAULT: assert property ((smp_valid_i && sample_i.fault) |-> ##2 fault_o)
    else $error("Reported fault not raised.");
  AST_POLL: assert property ((poll_tick && poll_st_q == heat_alarm_pkg::POLL_IDLE) |=>
            poll_req_o [*8] ##1 !poll_req_o)
    else $error("Poll round not eight queries.");
  AST_MAX_TRACK: assert property ((s_det0_hit ##0 (!midnight_i &&
                 sample_i.temp > run_max[0])) |=> run_max[0] == $past(sample_i.temp))
    else $error("Running maximum not updated.");
  AST_MIDNIGHT: assert property ((midnight_i && !smp_valid_i) |=>
                (st_max[0] == $past(run_max[0]) && run_max[0] == `MAX_INIT))
    else $error("Midnight store not taken.");
  AST_COINC_OFF: assert property (!coinc_on |=> (!zone_dep_o && !unit_dep_o))
    else $error("Dependent output with gating off.");
endmodule
`default_nettype wire

// ===== heat_loop_model.sv
// Behavioural model of the addressed heat detectors on the loop.
`timescale 1ns/10ps
`default_nettype none
module heat_loop_model (
  input  wire logic                clk_i,
  input  wire logic                poll_req_i,
  input  wire logic [2:0]          poll_addr_i,
  output var  logic                smp_valid_o,
  output var  heat_alarm_pkg::sample_t sample_o
);
  logic [7:0] temp_q [8];  // Present temperature of each detector.
  logic       fault_q [8]; // Self-check verdict of each detector.
  logic       go;          // A directed reading is pending.
  logic [2:0] go_det;      // Detector of the directed reading.
  logic       go_fast;     // Rate-of-rise flag of the directed reading.
  initial
  begin
    smp_valid_o = 1'b0;
    sample_o = '0;
    go = 1'b0;
    go_det = 3'h0;
    go_fast = 1'b0;
    foreach (temp_q[i])
    begin
      temp_q[i] = 8'h14;
      fault_q[i] = 1'b0;
    end
  end
  // Sets a detector's temperature and makes it report once.
  task automatic send(input logic [2:0] d, input logic [7:0] t, input logic f);
    @(posedge clk_i);
    temp_q[d] <= t;
    go <= 1'b1;
    go_det <= d;
    go_fast <= f;
    @(posedge clk_i);
    go <= 1'b0;
  endtask
  // Polled detectors answer with their self-check; idle lines toggle so stale data never looks valid.
  always @(posedge clk_i)
  begin
    smp_valid_o <= poll_req_i | go;
    if (poll_req_i)
      sample_o <= {poll_addr_i, temp_q[poll_addr_i], fault_q[poll_addr_i], 1'b0};
    else if (go)
      sample_o <= {go_det, temp_q[go_det], fault_q[go_det], go_fast};
    else
      sample_o <= ~sample_o;
  end
endmodule
`default_nettype wire

// ===== test_heat_alarm_coincidence_eval.sv
// Self-checking bench for the heat alarm evaluator.
`timescale 1ns/10ps
`default_nettype none
`include "heat_alarm_map.svh"
module test_heat_alarm_coincidence_eval;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic alt_tc_i = 1'b0, coinc_tc_i = 1'b0, midnight_i = 1'b0;
  logic ack_o, smp_valid_i, poll_req_o, fire_alarm_o, prewarn_o, heavy_o, fault_o;
  logic zone_dep_o, unit_dep_o, coinc_ind_o, buzzer_o, irq_o;
  logic [2:0] poll_addr_o;
  heat_alarm_pkg::sample_t sample_i;
  int mismatches = 0;
  int n_compared = 0;
  // Short buzzer and poll counts keep the run brief.
  heat_alarm_coincidence_eval #(.BUZ_PERIOD_CYC(50), .BUZ_ON_CYC(8), .POLL_CYC(30000)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .dat_i(dat_i), .sel_i(4'hf), .dat_o(dat_o), .ack_o(ack_o), .smp_valid_i(smp_valid_i),
    .sample_i(sample_i), .alt_tc_i(alt_tc_i), .coinc_tc_i(coinc_tc_i), .midnight_i(midnight_i),
    .poll_req_o(poll_req_o), .poll_addr_o(poll_addr_o), .fire_alarm_o(fire_alarm_o),
    .prewarn_o(prewarn_o), .heavy_o(heavy_o), .fault_o(fault_o), .zone_dep_o(zone_dep_o),
    .unit_dep_o(unit_dep_o), .coinc_ind_o(coinc_ind_o), .buzzer_o(buzzer_o), .irq_o(irq_o));
  heat_loop_model loop (.clk_i(clk_i), .poll_req_i(poll_req_o), .poll_addr_i(poll_addr_o),
    .smp_valid_o(smp_valid_i), .sample_o(sample_i));
  initial
    forever #10 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One classic cycle; read data is taken at the edge where ack is seen.
  // Only the watchdog ends a wait for an ack that never comes.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  function automatic logic [31:0] out(input int k);
    out = {29'h0, heavy_o, prewarn_o, fire_alarm_o} >> k & 32'h1;
  endfunction
  // Two hits, one at the level, two hits stay quiet; the next hit raises; a cool reading drops.
  task automatic confirm(input logic [2:0] d, input logic [7:0] lv, input logic f,
    input int k, input logic en);
    repeat (2) loop.send(d, lv + 8'h01, f);
    loop.send(d, lv, f);
    repeat (2) loop.send(d, lv + 8'h01, f);
    tick(5);
    chk(out(k), 32'h0);
    loop.send(d, lv + 8'h01, f);
    tick(5);
    chk(out(k), {31'h0, en});
    loop.send(d, 8'h14, f);
    tick(5);
    chk(out(k), 32'h0);
  endtask
  // A lone dependent alarm is held back and announced; its partner releases it.
  task automatic pair(input logic [2:0] a, input logic [2:0] b, input int k);
    int hi;
    repeat (3) loop.send(a, 8'h50, 1'b0);
    tick(5);
    chk(fire_alarm_o, 32'h0);
    chk({unit_dep_o, zone_dep_o} >> k & 2'h1, 32'h1);
    chk(coinc_ind_o, 32'h1);
    hi = 0;
    // Any fifty cycles span one whole period, so exactly the on time is heard.
    repeat (50) @(posedge clk_i) hi += buzzer_o;
    chk(hi, 32'h8);
    repeat (3) loop.send(b, 8'h50, 1'b0);
    tick(5);
    chk(fire_alarm_o, 32'h1);
    loop.send(a, 8'h14, 1'b0);
    loop.send(b, 8'h14, 1'b0);
  endtask
  task automatic await_fault(input logic v);
    int n;
    n = 0;
    while (fault_o !== v && n < 31000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(fault_o, {31'h0, v});
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    tick(3);
    rst_i <= 1'b0;
    wb(0, `STATUS_OFS, 0);
    chk(rd, 32'h0);
    loop.send(1, 8'h1e, 0);
    loop.send(1, 8'h46, 0);
    loop.send(1, 8'h32, 0);
    wb(0, 8'h44, 0);
    chk(rd, 32'h00ff);
    @(posedge clk_i) midnight_i <= 1'b1;
    @(posedge clk_i) midnight_i <= 1'b0;
    wb(0, 8'h44, 0);
    chk(rd, 32'h461e);
    wb(1, `CTRL_OFS, 1);
    wb(1, `IRQEN_OFS, 1);
    confirm(0, 8'h38, 0, 0, 1);
    chk(irq_o, 32'h1);
    wb(0, `STATUS_OFS, 0);
    chk(rd, 32'h3);
    wb(1, `CLEAR_OFS, 1);
    tick(2);
    chk(irq_o, 32'h0);
    wb(0, `STATUS_OFS, 0);
    chk(rd, 32'h2);
    confirm(0, 8'h2e, 0, 1, 1);
    confirm(0, 8'h5a, 0, 2, 1);
    confirm(0, 8'h2e, 1, 0, 1);
    confirm(0, 8'h24, 1, 1, 1);
    wb(1, `CLASS_OFS, 32'h0002_0001);
    confirm(0, 8'h3c, 0, 0, 1);
    confirm(0, 8'h32, 0, 1, 1);
    @(posedge clk_i) alt_tc_i <= 1'b1;
    confirm(0, 8'h4a, 0, 0, 1);
    confirm(0, 8'h40, 0, 1, 1);
    @(posedge clk_i) alt_tc_i <= 1'b0;
    wb(1, `CTRL_OFS, 0);
    confirm(0, 8'h32, 0, 1, 0);
    wb(1, `ZMAP_OFS, 32'h006d_1000);
    wb(1, `GROUP_OFS, 32'h330);
    wb(1, `UDEP_OFS, 32'hc0);
    @(posedge clk_i) coinc_tc_i <= 1'b1;
    pair(4, 5, 0);
    pair(6, 7, 1);
    @(posedge clk_i) coinc_tc_i <= 1'b0;
    confirm(4, 8'h38, 0, 0, 1);
    loop.fault_q[3] = 1'b1;
    await_fault(1'b1);
    loop.fault_q[3] = 1'b0;
    await_fault(1'b0);
    wrap_up();
  end
  initial
  begin
    tick(80000);
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
